// file: design/rpm_reset_power.sv
/*
  Reset and power-management controller: reset source collection, cause
  flags, shared reset pin, low-power modes and reset fetch vector.
  Assumes analog monitors and peripheral requests are levels or pulses in
  the system clock domain, except pin and detector inputs, which are
  synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
module rpm_reset_power
  import rpm_pkg::*;
#(
  parameter int HOLD_CYC = RPM_RST_HOLD_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic power_on_det_in,
  input wire logic brownout_det_in,
  input wire logic shared_reset_pin_in,
  input wire logic watchdog_reset_in,
  input wire logic uart_break_reset_in,
  input wire logic wake_irq_in,
  input wire logic enabled_irq_in,
  input wire logic boot_status_bit_in,
  input wire logic force_isp_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic cpu_reset_n_out,
  output logic pin_data_out,
  output logic [15:0] fetch_addr_out,
  output logic brownout_irq_out,
  output logic irq_out,
  output rpm_power_t power_out
);

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
    end else begin
      sync1_ff <= {power_on_det_in, brownout_det_in, shared_reset_pin_in};
      sync2_ff <= sync1_ff;
    end
  end
  wire logic pin_s = sync2_ff[0];
  wire logic bo_s = sync2_ff[1];
  wire logic por_s = sync2_ff[2];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [5:0] cause_ff;
  logic [6:0] ctrl_ff;
  logic [2:0] config_ff;
  logic [7:0] boot_vec_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic power_up_ff;
  logic boot_sel_ff;
  logic [7:0] hold_cnt_ff;
  logic break_seen_ff;
  rpm_mode_t mode_ff;
  rpm_mode_t nxt_mode;

  wire logic bo_active = ctrl_ff[RPM_CT_BO_DET_EN] && mode_ff != RPM_TOTAL_PD;
  wire logic bo_event = bo_active && bo_s;
  wire logic bo_reset = bo_event && !ctrl_ff[RPM_CT_BO_IRQ_MODE];
  wire logic bo_irq = bo_event && ctrl_ff[RPM_CT_BO_IRQ_MODE];
  wire logic pin_reset = !pin_s && (config_ff[RPM_CG_RESET_PIN_EN] || power_up_ff);
  wire logic sw_reset = ctrl_ff[RPM_CT_SW_RESET];
  wire logic any_reset = por_s || pin_reset || bo_reset || watchdog_reset_in ||
                         sw_reset || uart_break_reset_in;

  wire logic wr_cause = wr_in && addr_in == RPM_ADDR_CAUSE;
  wire logic wr_ctrl = wr_in && addr_in == RPM_ADDR_CTRL;
  wire logic wr_config = wr_in && addr_in == RPM_ADDR_CONFIG;
  wire logic wr_boot = wr_in && addr_in == RPM_ADDR_BOOT;
  wire logic wr_mask = wr_in && addr_in == RPM_ADDR_IRQ_MASK;
  wire logic rd_stat = rd_in && addr_in == RPM_ADDR_IRQ_STAT;

  wire logic [5:0] cause_set = {uart_break_reset_in, sw_reset, watchdog_reset_in,
                                bo_reset, 1'b0, pin_reset};
  wire logic [5:0] cause_keep = wr_cause ? (cause_ff & wdata_in[5:0]) : cause_ff;
  wire logic [5:0] nxt_cause = por_s ? RPM_CAUSE_POR_VAL : (cause_keep | cause_set);

  wire logic [1:0] irq_set = {wake_irq_in && mode_ff != RPM_RUN, bo_irq};
  // status clears on read; new events still land
  wire logic [1:0] nxt_irq_stat = (rd_stat ? 2'h0 : irq_stat_ff) | irq_set;

  // ------------------------------------------------------------
  // power mode sequencing
  // ------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      RPM_RUN: begin
        if (wr_ctrl && wdata_in[RPM_CT_TOTAL_PD])
          nxt_mode = RPM_TOTAL_PD;
        else if (wr_ctrl && wdata_in[RPM_CT_PD])
          nxt_mode = RPM_PD;
        else if (wr_ctrl && wdata_in[RPM_CT_IDLE])
          nxt_mode = RPM_IDLE;
      end
      RPM_IDLE: begin
        if (enabled_irq_in)
          nxt_mode = RPM_RUN;
      end
      RPM_PD, RPM_TOTAL_PD: begin
        if (wake_irq_in)
          nxt_mode = RPM_RUN;
      end
      default: nxt_mode = RPM_RUN;
    endcase
    if (any_reset)
      nxt_mode = RPM_RUN;
  end

  // boot vector selection
  // break carried only while the core is still held, so a later reset starts clean
  wire logic nxt_boot_sel = uart_break_reset_in || (break_seen_ff && !cpu_reset_n_out) ||
                            boot_status_bit_in || (por_s && force_isp_in);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cause_ff <= RPM_CAUSE_POR_VAL;
      ctrl_ff <= RPM_CTRL_RST;
      config_ff <= RPM_CONFIG_RST;
      boot_vec_ff <= RPM_BOOT_VEC_RST;
      irq_stat_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
      mode_ff <= RPM_RUN;
      power_up_ff <= 1'b1;
    end else begin
      cause_ff <= nxt_cause;
      irq_stat_ff <= nxt_irq_stat;
      mode_ff <= nxt_mode;
      if (wr_ctrl)
        ctrl_ff <= {wdata_in[6:3], 3'h0};
      else
        ctrl_ff[RPM_CT_SW_RESET] <= 1'b0;
      if (wr_config)
        config_ff <= wdata_in[2:0];
      if (wr_boot)
        boot_vec_ff <= wdata_in;
      if (wr_mask)
        irq_mask_ff <= wdata_in[1:0];
      // power-up window ends once pin and detector release
      if (por_s)
        power_up_ff <= 1'b1;
      else if (pin_s)
        power_up_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // reset stretch and vector
  // ------------------------------------------------------------
  // released only after all reset sources quiet for hold time
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_cnt_ff <= 8'h00;
      cpu_reset_n_out <= 1'b0;
      boot_sel_ff <= 1'b0;
      break_seen_ff <= 1'b0;
    end else begin
      if (any_reset) begin
        hold_cnt_ff <= 8'h00;
        cpu_reset_n_out <= 1'b0;
        break_seen_ff <= uart_break_reset_in || (break_seen_ff && !cpu_reset_n_out);
        boot_sel_ff <= nxt_boot_sel;
      end else if (hold_cnt_ff < HOLD_CYC[7:0]) begin
        hold_cnt_ff <= hold_cnt_ff + 8'h01;
      end else begin
        cpu_reset_n_out <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  wire logic [7:0] rd_mux =
    addr_in == RPM_ADDR_CAUSE ? {2'h0, cause_ff} :
    addr_in == RPM_ADDR_CTRL ? {1'b0, ctrl_ff} :
    addr_in == RPM_ADDR_CONFIG ? {5'h00, config_ff} :
    addr_in == RPM_ADDR_BOOT ? boot_vec_ff :
    addr_in == RPM_ADDR_IRQ_STAT ? {6'h00, irq_stat_ff} :
    addr_in == RPM_ADDR_IRQ_MASK ? {6'h00, irq_mask_ff} :
    addr_in == RPM_ADDR_STATE ? {5'h00, power_up_ff, mode_ff} : 8'h00;

  rpm_power_t nxt_power;
  always_comb begin
    nxt_power.main_osc_en = !(nxt_mode == RPM_PD || nxt_mode == RPM_TOTAL_PD);
    // RC oscillator follows the main oscillator; in power-down kept only when it clocks the running timer
    nxt_power.rc_osc_en = nxt_power.main_osc_en ||
                          (config_ff[RPM_CG_RC_IS_SYSCLK] && config_ff[RPM_CG_RTC_EN]);
    // detectors stay on in power-down, off in total power-down
    nxt_power.brownout_det_en = ctrl_ff[RPM_CT_BO_DET_EN] && nxt_mode != RPM_TOTAL_PD;
    nxt_power.comparator_en = !ctrl_ff[RPM_CT_CMP_OFF] && nxt_mode != RPM_TOTAL_PD;
    nxt_power.cpu_clk_en = nxt_mode == RPM_RUN;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
      pin_data_out <= 1'b1;
      fetch_addr_out <= RPM_ZERO_VECTOR;
      brownout_irq_out <= 1'b0;
      irq_out <= 1'b0;
      power_out <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
      // plain input when pin reset disabled
      pin_data_out <= pin_s;
      fetch_addr_out <= boot_sel_ff ? {boot_vec_ff, RPM_LOW_BYTE} : RPM_ZERO_VECTOR;
      brownout_irq_out <= bo_irq;
      irq_out <= |(nxt_irq_stat & irq_mask_ff);
      power_out <= nxt_power;
    end
  end

endmodule
`default_nettype wire

// file: design/rpm_pkg.sv
/*
  Package for the reset and power-management controller: register offsets,
  field positions, reset values and shared types.
  Assumes a single 100 MHz system clock and a plain strobe register port.
*/
package rpm_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] RPM_ADDR_CAUSE = 4'h0;
  localparam logic [3:0] RPM_ADDR_CTRL = 4'h1;
  localparam logic [3:0] RPM_ADDR_CONFIG = 4'h2;
  localparam logic [3:0] RPM_ADDR_BOOT = 4'h3;
  localparam logic [3:0] RPM_ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] RPM_ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] RPM_ADDR_STATE = 4'h6;

  // ------------------------------------------------------------
  // cause flag positions
  // ------------------------------------------------------------
  localparam int RPM_CF_PIN = 0;
  localparam int RPM_CF_POWER_ON = 1;
  localparam int RPM_CF_BROWNOUT = 2;
  localparam int RPM_CF_WATCHDOG = 3;
  localparam int RPM_CF_SOFTWARE = 4;
  localparam int RPM_CF_BREAK = 5;

  // control register bits
  localparam int RPM_CT_IDLE = 0;
  localparam int RPM_CT_PD = 1;
  localparam int RPM_CT_TOTAL_PD = 2;
  localparam int RPM_CT_SW_RESET = 3;
  localparam int RPM_CT_BO_DET_EN = 4;
  localparam int RPM_CT_BO_IRQ_MODE = 5;
  localparam int RPM_CT_CMP_OFF = 6;

  // config register bits
  localparam int RPM_CG_RESET_PIN_EN = 0;
  localparam int RPM_CG_RC_IS_SYSCLK = 1;
  localparam int RPM_CG_RTC_EN = 2;

  // interrupt status bits
  localparam int RPM_IS_BROWNOUT = 0;
  localparam int RPM_IS_WAKE = 1;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [5:0] RPM_CAUSE_POR_VAL = 6'h06;
  localparam logic [6:0] RPM_CTRL_RST = 7'h10;
  localparam logic [2:0] RPM_CONFIG_RST = 3'h1;
  localparam logic [7:0] RPM_BOOT_VEC_RST = 8'h1F;
  localparam logic [7:0] RPM_LOW_BYTE = 8'h00;
  localparam logic [15:0] RPM_ZERO_VECTOR = 16'h0000;
  localparam int RPM_RST_HOLD_NS = 80;
  localparam int RPM_CLK_NS = 10;
  localparam int RPM_RST_HOLD_CYC = (RPM_RST_HOLD_NS + RPM_CLK_NS - 1) / RPM_CLK_NS;

  typedef enum logic [1:0] {
    RPM_RUN,
    RPM_IDLE,
    RPM_PD,
    RPM_TOTAL_PD
  } rpm_mode_t;

  // power gating outputs that travel together
  typedef struct packed {
    logic main_osc_en;
    logic rc_osc_en;
    logic brownout_det_en;
    logic comparator_en;
    logic cpu_clk_en;
  } rpm_power_t;

endpackage

// file: sim/rpm_reset_power_chk.sv
/* Port checker for the reset and power controller.
   Assumes HOLD_CYC matches the bound instance. */
`timescale 1ns/10ps
`default_nettype none
module rpm_chk
  import rpm_pkg::*;
#(
  parameter int HOLD_CYC = RPM_RST_HOLD_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic brownout_det_in,
  input wire logic watchdog_reset_in,
  input wire logic uart_break_reset_in,
  input wire logic wake_irq_in,
  input wire logic enabled_irq_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic cpu_reset_n_out,
  input wire logic [15:0] fetch_addr_out,
  input wire logic brownout_irq_out,
  input wire rpm_power_t power_out
);
  // cycles since the last watchdog or break reset request
  logic [7:0] quiet_ff;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) quiet_ff <= 8'h00;
    else if (watchdog_reset_in || uart_break_reset_in) quiet_ff <= 8'h00;
    else if (quiet_ff != 8'hFF) quiet_ff <= quiet_ff + 8'h01;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_rdata_idle: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00) else $error("read data outside read slot");
  a_bo_cause: assert property (
    $rose(brownout_irq_out) |-> $past(brownout_det_in) || $past(brownout_det_in, 2)
      || $past(brownout_det_in, 3) || $past(brownout_det_in, 4))
    else $error("brownout request without brownout");
  a_wdog_reset: assert property (
    watchdog_reset_in |-> ##[1:3] !cpu_reset_n_out) else $error("watchdog gave no reset");
  a_fetch_low: assert property (
    fetch_addr_out[7:0] == RPM_LOW_BYTE) else $error("fetch low byte not zero");
  a_reset_hold: assert property (
    $rose(cpu_reset_n_out) |-> quiet_ff >= HOLD_CYC) else $error("core reset released early");
  a_reset_runs: assert property (
    !cpu_reset_n_out [*3] |-> power_out.main_osc_en && power_out.cpu_clk_en)
    else $error("reset left core stopped");
  a_bo_gate: assert property (
    !power_out.brownout_det_en [*3] |-> !brownout_irq_out) else $error("brownout irq while off");
  a_pd_clk: assert property (
    !power_out.main_osc_en |-> !power_out.cpu_clk_en) else $error("core clocked in power-down");
  a_wake_pd: assert property (
    wake_irq_in && !power_out.main_osc_en |-> ##[1:4] power_out.main_osc_en)
    else $error("no wake from power-down");
  a_idle_exit: assert property (
    enabled_irq_in && !power_out.cpu_clk_en && power_out.main_osc_en
      |-> ##[1:4] power_out.cpu_clk_en) else $error("no exit from idle");
  c_pd: cover property (!power_out.main_osc_en);
  c_bo_irq: cover property ($rose(brownout_irq_out));
  c_release: cover property ($rose(cpu_reset_n_out));
endmodule
bind rpm_reset_power rpm_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (.sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in), .brownout_det_in(brownout_det_in),
  .watchdog_reset_in(watchdog_reset_in), .uart_break_reset_in(uart_break_reset_in),
  .wake_irq_in(wake_irq_in), .enabled_irq_in(enabled_irq_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .cpu_reset_n_out(cpu_reset_n_out), .fetch_addr_out(fetch_addr_out),
  .brownout_irq_out(brownout_irq_out), .power_out(power_out));
`default_nettype wire

// file: sim/rpm_core_model.sv
/* Core and peripheral side: reset and interrupt requests, shared pin.
   Assumes callers start tasks off the clock edge. */
`timescale 1ns/10ps
`default_nettype none
module rpm_core_model (
  input wire logic sys_clk_in,
  output logic wdog_out,
  output logic break_out,
  output logic wake_out,
  output logic irq_out,
  output logic pin_out
);
  logic [3:0] req_vec;
  assign {irq_out, wake_out, break_out, wdog_out} = req_vec;
  initial begin
    req_vec = 4'h0;
    pin_out = 1'b1;
  end
  task automatic req(input int k);
    @(posedge sys_clk_in) req_vec[k] <= 1'b1;
    @(posedge sys_clk_in) req_vec[k] <= 1'b0;
  endtask
  task automatic set_pin(input logic v);
    @(posedge sys_clk_in) pin_out <= v;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
/* Self-checking bench for the reset and power controller.
   Assumes the core model drives requests and the shared pin. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rpm_pkg::*;
  logic clk = 1'b0;
  logic rst_n;
  logic por_det;
  logic bo_det;
  logic bstat;
  logic in_system_programming_mode;
  logic wr;
  logic rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wdog, brk, wake, eirq, pin, pin_q, bo_irq, irq, core_rst_n;
  logic [7:0] rdata;
  logic [15:0] fetch;
  rpm_power_t pwr;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  rpm_core_model core (.sys_clk_in(clk), .wdog_out(wdog), .break_out(brk), .wake_out(wake),
    .irq_out(eirq), .pin_out(pin));
  // short hold keeps reset waits brief
  rpm_reset_power #(.HOLD_CYC(2)) dut (.sys_clk_in(clk), .reset_n_in(rst_n),
    .power_on_det_in(por_det), .brownout_det_in(bo_det), .shared_reset_pin_in(pin),
    .watchdog_reset_in(wdog), .uart_break_reset_in(brk), .wake_irq_in(wake),
    .enabled_irq_in(eirq), .boot_status_bit_in(bstat), .force_isp_in(in_system_programming_mode), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cpu_reset_n_out(core_rst_n),
    .pin_data_out(pin_q), .fetch_addr_out(fetch), .brownout_irq_out(bo_irq), .irq_out(irq),
    .power_out(pwr));
  task automatic give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wait_core(input logic lvl);
    for (int i = 0; i < 60 && core_rst_n !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    chk(core_rst_n, lvl);
  endtask
  task automatic cycle_core;
    wait_core(1'b0);
    wait_core(1'b1);
  endtask
  task automatic t_power_on;
    rd_chk(RPM_ADDR_CAUSE, 8'h06);
    rd_chk(RPM_ADDR_CTRL, 8'h10);
    rd_chk(RPM_ADDR_CONFIG, 8'h01);
    rd_chk(RPM_ADDR_BOOT, 8'h1F);
    rd_chk(4'h7, 8'h00);
    chk(fetch, 16'h0000);
  endtask
  task automatic t_flags;
    wr_reg(RPM_ADDR_CAUSE, 8'h04);
    rd_chk(RPM_ADDR_CAUSE, 8'h04);
    core.req(0);
    cycle_core();
    rd_chk(RPM_ADDR_CAUSE, 8'h0C);
    wr_reg(RPM_ADDR_CTRL, 8'h18);
    cycle_core();
    rd_chk(RPM_ADDR_CAUSE, 8'h1C);
    core.req(1);
    cycle_core();
    rd_chk(RPM_ADDR_CAUSE, 8'h3C);
    chk(fetch, 16'h1F00);
    core.req(0);
    cycle_core();
    chk(fetch, 16'h0000);
    @(posedge clk) bstat <= 1'b1;
    core.req(0);
    cycle_core();
    chk(fetch, 16'h1F00);
    @(posedge clk) bstat <= 1'b0;
    wr_reg(RPM_ADDR_CAUSE, 8'h00);
    rd_chk(RPM_ADDR_CAUSE, 8'h00);
  endtask
  task automatic t_brownout;
    logic irq_a;
    @(posedge clk) bo_det <= 1'b1;
    wait_core(1'b0);
    @(posedge clk) bo_det <= 1'b0;
    wait_core(1'b1);
    rd_chk(RPM_ADDR_CAUSE, 8'h04);
    wr_reg(RPM_ADDR_CTRL, 8'h30);
    wr_reg(RPM_ADDR_IRQ_MASK, 8'h00);
    @(posedge clk) bo_det <= 1'b1;
    settle();
    chk({core_rst_n, bo_irq}, 2'b11);
    irq_a = irq;
    wr_reg(RPM_ADDR_IRQ_MASK, 8'hFF);
    settle();
    chk({irq_a, irq}, 2'b01);
    @(posedge clk) bo_det <= 1'b0;
    settle();
    rd_chk(RPM_ADDR_IRQ_STAT, 8'h01);
    rd_chk(RPM_ADDR_IRQ_STAT, 8'h00);
    chk({irq, bo_irq}, 2'b00);
    wr_reg(RPM_ADDR_CTRL, 8'h00);
    @(posedge clk) bo_det <= 1'b1;
    settle();
    chk({core_rst_n, bo_irq}, 2'b10);
    @(posedge clk) bo_det <= 1'b0;
    rd_chk(RPM_ADDR_IRQ_STAT, 8'h00);
  endtask
  task automatic t_modes;
    wr_reg(RPM_ADDR_CONFIG, 8'h01);
    wr_reg(RPM_ADDR_CTRL, 8'h11);
    settle();
    chk({pwr.main_osc_en, pwr.cpu_clk_en}, 2'b10);
    core.req(3);
    settle();
    chk(pwr.cpu_clk_en, 1'b1);
    wr_reg(RPM_ADDR_CTRL, 8'h12);
    settle();
    chk(pwr, 5'b00110);
    core.req(2);
    settle();
    chk({pwr.main_osc_en, pwr.cpu_clk_en}, 2'b11);
    wr_reg(RPM_ADDR_CTRL, 8'h14);
    settle();
    chk(pwr, 5'b00000);
    @(posedge clk) bo_det <= 1'b1;
    settle();
    chk({core_rst_n, bo_irq}, 2'b10);
    @(posedge clk) bo_det <= 1'b0;
    settle();
    core.req(2);
    settle();
    chk({pwr.main_osc_en, pwr.cpu_clk_en}, 2'b11);
    wr_reg(RPM_ADDR_CONFIG, 8'h07);
    wr_reg(RPM_ADDR_CTRL, 8'h12);
    settle();
    chk(pwr.rc_osc_en, 1'b1);
    core.req(0);
    cycle_core();
    settle();
    chk({pwr.main_osc_en, pwr.cpu_clk_en}, 2'b11);
  endtask
  task automatic t_pin;
    wr_reg(RPM_ADDR_CONFIG, 8'h01);
    wr_reg(RPM_ADDR_CAUSE, 8'h00);
    core.set_pin(1'b0);
    wait_core(1'b0);
    core.set_pin(1'b1);
    wait_core(1'b1);
    rd_chk(RPM_ADDR_CAUSE, 8'h01);
    wr_reg(RPM_ADDR_CONFIG, 8'h00);
    core.set_pin(1'b0);
    settle();
    chk({core_rst_n, pin_q}, 2'b10);
    core.set_pin(1'b1);
    settle();
    chk(pin_q, 1'b1);
  endtask
  task automatic t_power_up;
    @(posedge clk) begin
      por_det <= 1'b1;
      in_system_programming_mode <= 1'b1;
    end
    wait_core(1'b0);
    @(posedge clk) por_det <= 1'b0;
    wait_core(1'b1);
    chk(fetch, 16'h1F00);
    @(posedge clk) in_system_programming_mode <= 1'b0;
    rd_chk(RPM_ADDR_CAUSE, 8'h06);
    core.set_pin(1'b0);
    @(posedge clk) por_det <= 1'b1;
    wait_core(1'b0);
    @(posedge clk) por_det <= 1'b0;
    settle();
    chk(core_rst_n, 1'b0);
    core.set_pin(1'b1);
    wait_core(1'b1);
    chk(fetch, 16'h0000);
  endtask
  initial begin
    rst_n = 1'b0;
    por_det = 1'b1;
    bo_det = 1'b0;
    bstat = 1'b0;
    in_system_programming_mode = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    por_det <= 1'b0;
    wait_core(1'b1);
    t_power_on();
    t_flags();
    t_brownout();
    t_modes();
    t_pin();
    t_power_up();
    give_verdict();
  end
  // whole run needs well under 2000 cycles
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
